// >>> rtl/ufis_pkg.sv
package ufis_pkg;
	localparam logic [7:0] CSR_OFFSET = 8'h00;
	localparam logic [7:0] UCR_OFFSET = 8'h04;
	localparam logic [7:0] DBUF_OFFSET = 8'h08;
	localparam logic [7:0] IST_OFFSET = 8'h0C;
	localparam logic [7:0] IMSK_OFFSET = 8'h10;
	localparam int CSR_MODE_BIT = 7;
	localparam int CSR_RE_BIT = 6;
	localparam int CSR_SLAVE_BIT = 5;
	localparam int CSR_FE_BIT = 4;
	localparam int CSR_ERR_BIT = 3;
	localparam int CSR_RXB_BIT = 2;
	localparam int CSR_TXB_BIT = 1;
	localparam int UCR_FLUSH_BIT = 7;
	localparam int IRQ_W = 4;
	localparam int IRQ_RX_BIT = 0;
	localparam int IRQ_TX_BIT = 1;
	localparam int IRQ_FE_BIT = 2;
	localparam int IRQ_PE_BIT = 3;
	localparam logic [3:0] IMSK_RESET = 4'h0;
	localparam logic [7:0] DBUF_RESET = 8'h00;
	typedef struct packed {
		logic rx_done;
		logic tx_start;
		logic tx_done;
		logic frame_err;
		logic parity_err;
		logic busy;
		logic bit_end;
		logic [7:0] rx_data;
	} ufis_core_ev_type;
	typedef struct packed {
		logic uart_mode;
		logic rx_enable;
		logic spi_slave;
		logic flush;
		logic tx_load;
		logic [7:0] tx_data;
	} ufis_core_ctl_type;
endpackage : ufis_pkg

// >>> rtl/ufis_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module ufis_sticky #(
	parameter int W = 4
) (
	// clock
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// flags
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	// set wins so an event in the clearing cycle survives
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else if (ce)
			q <= set | (q & ~clr);
	end
endmodule : ufis_sticky
`default_nettype wire

// >>> rtl/ufis_usart_ctl.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ufis_usart_ctl (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial engine
	input wire ufis_pkg::ufis_core_ev_type ev,
	output ufis_pkg::ufis_core_ctl_type ctl,
	// slave select pin, active low
	input wire logic ssn_n,
	// event pulses and interrupt
	output logic rx_complete_irq,
	output logic tx_irq,
	output logic dma_rx_trig,
	output logic dma_tx_trig,
	output logic irq
);
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic mode_reg;
	logic re_reg;
	logic slave_reg;
	logic fe_reg;
	logic err_reg;
	logic rxb_reg;
	logic txb_reg;
	logic active_reg;
	logic [7:0] rxd_reg;
	logic flush_pend_reg;
	logic flush_reg;
	logic load_reg;
	logic [7:0] txd_reg;
	logic rxi_reg;
	logic txi_reg;
	logic irq_reg;
	logic [3:0] msk_reg;
	logic [3:0] ist;
	logic [1:0] ssn_sync;
	logic [7:0] rd_mux;
	logic hit;
	logic wr;
	logic rd;
	logic flush_wr;
	logic rx_set;
	logic flush_go;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign flush_wr = wr && paddr == ufis_pkg::UCR_OFFSET && pwdata[ufis_pkg::UCR_FLUSH_BIT];
	assign rx_set = ev.rx_done && (mode_reg || slave_reg) && !flush_pend_reg && !flush_wr;
	// the bit in flight ends before the engine is reset
	assign flush_go = flush_pend_reg && (ev.bit_end || !ev.busy);

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign ctl = '{mode_reg, re_reg, slave_reg, flush_reg, load_reg, txd_reg};
	assign rx_complete_irq = rxi_reg;
	assign tx_irq = txi_reg;
	assign dma_rx_trig = rxi_reg;
	assign dma_tx_trig = txi_reg;
	assign irq = irq_reg;

	always_comb
	begin
		hit = 1'b1;
		case (paddr)
			ufis_pkg::CSR_OFFSET: rd_mux = {mode_reg, re_reg, slave_reg, fe_reg, err_reg,
				rxb_reg, txb_reg, active_reg};
			ufis_pkg::UCR_OFFSET: rd_mux = 8'h00;
			ufis_pkg::DBUF_OFFSET: rd_mux = rxd_reg;
			ufis_pkg::IST_OFFSET: rd_mux = {4'h0, ist};
			ufis_pkg::IMSK_OFFSET: rd_mux = {4'h0, msk_reg};
			default:
			begin
				rd_mux = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	// read data sampled in setup so the access phase needs no wait
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else if (ce)
		begin
			pready_reg <= 1'b1;
			if (psel && !penable)
			begin
				pslverr_reg <= !hit;
				prdata_reg <= pwrite ? 32'h0 : {24'h0, rd_mux};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_reg <= 1'b0;
			re_reg <= 1'b0;
			slave_reg <= 1'b0;
			msk_reg <= ufis_pkg::IMSK_RESET;
		end
		else if (ce && wr)
		begin
			if (paddr == ufis_pkg::CSR_OFFSET)
			begin
				mode_reg <= pwdata[ufis_pkg::CSR_MODE_BIT];
				re_reg <= pwdata[ufis_pkg::CSR_RE_BIT];
				slave_reg <= pwdata[ufis_pkg::CSR_SLAVE_BIT];
			end
			if (paddr == ufis_pkg::IMSK_OFFSET)
				msk_reg <= pwdata[3:0];
		end
	end

	// error flags: hardware set beats the read clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fe_reg <= 1'b0;
			err_reg <= 1'b0;
		end
		else if (ce)
		begin
			if (ev.frame_err)
				fe_reg <= 1'b1;
			else if (rd && paddr == ufis_pkg::CSR_OFFSET)
				fe_reg <= 1'b0;
			else if (wr && paddr == ufis_pkg::CSR_OFFSET && !pwdata[ufis_pkg::CSR_FE_BIT])
				fe_reg <= 1'b0;
			if (ev.parity_err)
				err_reg <= 1'b1;
			else if (rd && paddr == ufis_pkg::CSR_OFFSET)
				err_reg <= 1'b0;
			else if (wr && paddr == ufis_pkg::CSR_OFFSET && !pwdata[ufis_pkg::CSR_ERR_BIT])
				err_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxb_reg <= 1'b0;
			rxd_reg <= ufis_pkg::DBUF_RESET;
		end
		else if (ce)
		begin
			if (rx_set)
			begin
				rxb_reg <= 1'b1;
				rxd_reg <= ev.rx_data;
			end
			else if (flush_wr || (wr && paddr == ufis_pkg::CSR_OFFSET
				&& !pwdata[ufis_pkg::CSR_RXB_BIT]))
			begin
				rxb_reg <= 1'b0;
				rxd_reg <= ufis_pkg::DBUF_RESET;
			end
			else if (rd && paddr == ufis_pkg::DBUF_OFFSET)
				rxb_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			txb_reg <= 1'b0;
		else if (ce)
		begin
			if (ev.tx_done && (mode_reg || !slave_reg))
				txb_reg <= 1'b1;
			else if (wr && paddr == ufis_pkg::CSR_OFFSET && !pwdata[ufis_pkg::CSR_TXB_BIT])
				txb_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ssn_sync <= 2'b11;
		else if (ce)
			ssn_sync <= {ssn_sync[0], ssn_n};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			active_reg <= 1'b0;
		else if (ce)
			active_reg <= (!mode_reg && slave_reg) ? !ssn_sync[1] : ev.busy;
	end

	// flush: tx load dropped at once, engine reset waits for bit end unless the engine is idle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flush_pend_reg <= 1'b0;
			flush_reg <= 1'b0;
			load_reg <= 1'b0;
			txd_reg <= ufis_pkg::DBUF_RESET;
		end
		else if (ce)
		begin
			flush_reg <= flush_go;
			if (flush_wr)
				flush_pend_reg <= 1'b1;
			else if (flush_go)
				flush_pend_reg <= 1'b0;
			load_reg <= wr && paddr == ufis_pkg::DBUF_OFFSET && !flush_pend_reg;
			if (flush_wr)
				txd_reg <= ufis_pkg::DBUF_RESET;
			else if (wr && paddr == ufis_pkg::DBUF_OFFSET)
				txd_reg <= pwdata[7:0];
		end
	end

	// one flop per event keeps each request a single pulse
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxi_reg <= 1'b0;
			txi_reg <= 1'b0;
			irq_reg <= 1'b0;
		end
		else if (ce)
		begin
			rxi_reg <= ev.rx_done && !rxi_reg;
			txi_reg <= ev.tx_start && !txi_reg;
			irq_reg <= |(ist & msk_reg);
		end
	end

	ufis_sticky #(
		.W(ufis_pkg::IRQ_W)
	) u_ist (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.set({ev.parity_err, ev.frame_err, ev.tx_start, ev.rx_done}),
		.clr((wr && paddr == ufis_pkg::IST_OFFSET) ? pwdata[3:0] : 4'h0),
		.q(ist)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	a_flush_clears_rx: assert property (flush_wr |=> !rxb_reg && rxd_reg == 8'h00)
		else $error("flush left receive data");
	a_flush_waits_bit: assert property (flush_wr && ev.busy && !ev.bit_end
		|=> !flush_reg)
		else $error("flush reset engine mid bit");
	a_rx_irq_pulse: assert property (ev.rx_done && !rxi_reg |=> rxi_reg ##1 !rxi_reg)
		else $error("rx request not one pulse");
	a_tx_irq_start: assert property (ev.tx_start && !txi_reg |=> txi_reg)
		else $error("tx request missed");
	a_dma_same_events: assert property (dma_rx_trig == rxi_reg && dma_tx_trig == txi_reg)
		else $error("dma trigger differs from request");
	a_mode_write: assert property (wr && paddr == 8'h00
		|=> ctl.uart_mode == $past(pwdata[7]) && ctl.spi_slave == $past(pwdata[5]))
		else $error("mode select not written");
	a_rxen_write: assert property (wr && paddr == 8'h00 |=> ctl.rx_enable == $past(pwdata[6]))
		else $error("receiver enable not written");
	a_fe_read_clear: assert property (rd && paddr == 8'h00 && !ev.frame_err |=> !fe_reg)
		else $error("framing flag survived read");
	a_err_read_clear: assert property (rd && paddr == 8'h00 && !ev.parity_err |=> !err_reg)
		else $error("parity flag survived read");
	a_rxb_set: assert property (rx_set |=> rxb_reg && rxd_reg == $past(ev.rx_data))
		else $error("received byte not flagged");
	a_txb_set: assert property (ev.tx_done && mode_reg |=> txb_reg)
		else $error("tx done not flagged");
	a_active_slave: assert property (!mode_reg && slave_reg && $stable(ssn_sync[1])
		|=> active_reg == !$past(ssn_sync[1]))
		else $error("active not mirroring select");
	a_flush_one_shot: assert property (flush_reg |=> !flush_reg)
		else $error("flush not one-shot");
	a_flush_ends: assert property (flush_pend_reg && !ev.busy && !flush_wr
		|=> flush_reg && !flush_pend_reg)
		else $error("idle flush did not complete");
	a_rx_single: assert property (rxi_reg |-> $past(ev.rx_done))
		else $error("rx pulse without event");

	c_flush_mid_bit: cover property (flush_pend_reg && ev.busy ##[1:50] flush_reg);
	c_rx_irq: cover property (rxi_reg && msk_reg[0] ##1 irq_reg);
	c_fe_then_read: cover property (fe_reg ##[1:20] rd && paddr == 8'h00);
	c_slave_active: cover property (!mode_reg && slave_reg && active_reg);
endmodule : ufis_usart_ctl
`default_nettype wire

// >>> test/ufis_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufis_engine_model (
	// clock
	input wire logic clk,
	input wire logic rst_n,
	// block side
	input wire ufis_pkg::ufis_core_ctl_type ctl,
	output ufis_pkg::ufis_core_ev_type ev,
	// bench commands
	input wire logic rx_go,
	input wire logic [7:0] rx_val,
	input wire logic rx_fe,
	input wire logic rx_pe
);
	logic [4:0] cnt_reg;
	logic [4:0] cnt_next;
	always_comb
	begin
		if (ctl.flush)
			cnt_next = 5'h00;
		else if (ctl.tx_load)
			cnt_next = 5'h10;
		else if (cnt_reg != 5'h00)
			cnt_next = cnt_reg - 5'h01;
		else
			cnt_next = cnt_reg;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ev <= '0;
			cnt_reg <= 5'h00;
		end
		else
		begin
			cnt_reg <= cnt_next;
			ev.rx_done <= rx_go;
			ev.frame_err <= rx_go & rx_fe;
			ev.parity_err <= rx_go & rx_pe;
			// data outside rx_done is scrambled so nothing leans on stale bytes
			ev.rx_data <= rx_go ? rx_val : ~ev.rx_data;
			ev.tx_start <= ctl.tx_load;
			ev.busy <= (cnt_next != 5'h00);
			ev.bit_end <= (cnt_next != 5'h00) & cnt_next[0];
			ev.tx_done <= (cnt_reg == 5'h01) & ~ctl.flush & ~ctl.tx_load;
		end
	end
endmodule : ufis_engine_model
`default_nettype wire

// >>> test/ufis_usart_ctl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ufis_usart_ctl_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic ssn_n = 1'b1;
	logic rx_go = 1'b0;
	logic [7:0] rx_val = 8'h00;
	logic rx_fe = 1'b0;
	logic rx_pe = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, rx_irq, tx_irq, dma_rx, dma_tx, irq, prev_ok;
	logic [7:0] b;
	logic ce = 1'b1;
	logic [7:0] tx_exp = 8'h00;
	logic [7:0] rx_q[$];
	ufis_pkg::ufis_core_ev_type ev;
	ufis_pkg::ufis_core_ctl_type ctl;
	int error_cnt = 0;
	int checked = 0;
	int n_rx = 0;
	int n_tx = 0;
	int n_fl = 0;
	int seed = 32'h5ede;
	always #2 clk = ~clk;
	ufis_usart_ctl uut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ev(ev), .ctl(ctl), .ssn_n(ssn_n), .rx_complete_irq(rx_irq),
		.tx_irq(tx_irq), .dma_rx_trig(dma_rx), .dma_tx_trig(dma_tx), .irq(irq));
	ufis_engine_model eng (.clk(clk), .rst_n(rst_n), .ctl(ctl), .ev(ev), .rx_go(rx_go),
		.rx_val(rx_val), .rx_fe(rx_fe), .rx_pe(rx_pe));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h000000, d}, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic err);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h00000000, q, e);
		chk("read data", q, {24'h000000, x});
		chk("slave error", e, err);
	endtask : rd
	task automatic rx(input logic [7:0] v, input logic f, input logic p);
		rx_q.push_back(v);
		@(posedge clk);
		rx_go <= 1'b1;
		rx_val <= v;
		rx_fe <= f;
		rx_pe <= p;
		@(posedge clk);
		rx_go <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : rx
	task summarize;
		if (error_cnt == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	always @(posedge clk)
	begin
		prev_ok <= ev.bit_end | ~ev.busy;
		if (ctl.flush === 1'b1)
		begin
			n_fl++;
			chk("flush at bit end", prev_ok, 1'b1);
		end
		if (rx_irq === 1'b1)
			n_rx++;
		if (tx_irq === 1'b1)
			n_tx++;
		if (ctl.tx_load === 1'b1)
			chk("tx data", ctl.tx_data, tx_exp);
		chk("dma rx copy", dma_rx, rx_irq);
		chk("dma tx copy", dma_tx, tx_irq);
	end
	initial
	begin
		#40000;
		error_cnt++;
		summarize();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(ufis_pkg::CSR_OFFSET, 8'h00, 1'b0);
		rd(ufis_pkg::UCR_OFFSET, 8'h00, 1'b0);
		rd(8'h14, 8'h00, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			b = 8'($random(seed)) & 8'hE0;
			wr(ufis_pkg::CSR_OFFSET, b);
			rd(ufis_pkg::CSR_OFFSET, b, 1'b0);
			chk("mode", {ctl.uart_mode, ctl.rx_enable, ctl.spi_slave}, b[7:5]);
		end
		wr(ufis_pkg::CSR_OFFSET, 8'h20);
		ssn_n <= 1'b0;
		repeat (3) @(posedge clk);
		rd(ufis_pkg::CSR_OFFSET, 8'h21, 1'b0);
		ssn_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ufis_pkg::CSR_OFFSET, 8'h20, 1'b0);
		// a write while the enable is low must leave every register as it was
		ce <= 1'b0;
		wr(ufis_pkg::CSR_OFFSET, 8'hC0);
		ce <= 1'b1;
		rd(ufis_pkg::CSR_OFFSET, 8'h20, 1'b0);
		wr(ufis_pkg::CSR_OFFSET, 8'hC0);
		b = 8'($random(seed));
		rx(b, 1'b1, 1'b1);
		chk("rx pulses", n_rx, 1);
		chk("irq masked", irq, 1'b0);
		rd(ufis_pkg::IST_OFFSET, 8'h0D, 1'b0);
		wr(ufis_pkg::IMSK_OFFSET, 8'h0F);
		repeat (2) @(posedge clk);
		chk("irq unmasked", irq, 1'b1);
		rd(ufis_pkg::CSR_OFFSET, 8'hDC, 1'b0);
		rd(ufis_pkg::CSR_OFFSET, 8'hC4, 1'b0);
		rd(ufis_pkg::DBUF_OFFSET, rx_q.pop_front(), 1'b0);
		rd(ufis_pkg::CSR_OFFSET, 8'hC0, 1'b0);
		wr(ufis_pkg::IST_OFFSET, 8'h0F);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 1'b0);
		rd(ufis_pkg::IST_OFFSET, 8'h00, 1'b0);
		rx(8'($random(seed)), 1'b0, 1'b0);
		wr(ufis_pkg::CSR_OFFSET, 8'hC0);
		rx_q.delete();
		rd(ufis_pkg::CSR_OFFSET, 8'hC0, 1'b0);
		rd(ufis_pkg::DBUF_OFFSET, ufis_pkg::DBUF_RESET, 1'b0);
		tx_exp = 8'($random(seed));
		wr(ufis_pkg::DBUF_OFFSET, tx_exp);
		// busy reaches the status bit two edges after the load pulse
		repeat (2) @(posedge clk);
		rd(ufis_pkg::CSR_OFFSET, 8'hC1, 1'b0);
		while (ev.busy !== 1'b0)
			@(posedge clk);
		chk("tx pulses", n_tx, 1);
		rd(ufis_pkg::CSR_OFFSET, 8'hC2, 1'b0);
		wr(ufis_pkg::CSR_OFFSET, 8'hC0);
		rd(ufis_pkg::CSR_OFFSET, 8'hC0, 1'b0);
		rx(8'($random(seed)), 1'b0, 1'b0);
		tx_exp = 8'($random(seed));
		wr(ufis_pkg::DBUF_OFFSET, tx_exp);
		// one extra edge lands the flush inside a bit, and the bit end comes in its first pending cycle
		@(posedge clk);
		wr(ufis_pkg::UCR_OFFSET, 8'h80);
		rx_q.delete();
		rd(ufis_pkg::UCR_OFFSET, 8'h00, 1'b0);
		// software side waits out two bits before touching the unit again
		repeat (4) @(posedge clk);
		rd(ufis_pkg::CSR_OFFSET, 8'hC0, 1'b0);
		rd(ufis_pkg::DBUF_OFFSET, ufis_pkg::DBUF_RESET, 1'b0);
		chk("flush pulses", n_fl, 1);
		// a flush on an idle unit completes without waiting for a bit end
		wr(ufis_pkg::UCR_OFFSET, 8'h80);
		repeat (3) @(posedge clk);
		chk("idle flush pulses", n_fl, 2);
		summarize();
	end
endmodule : ufis_usart_ctl_tb
`default_nettype wire
